/* File: rtl/upfs_pkg.sv */
// Shared constants and types for the serial pin function select block
package upfs_pkg;

  // ****************************************************************
  // Structure
  // ****************************************************************
  localparam int UPFS_NCH          = 2;
  localparam int UPFS_NPIN         = 5;
  localparam int UPFS_ADDR_W       = 12;
  localparam int UPFS_IDX_W        = 10;
  localparam int UPFS_DATA_W       = 32;

  // Pin slots within one channel
  localparam int UPFS_PIN_FLOW_IN  = 0;
  localparam int UPFS_PIN_HALFDUP  = 1;
  localparam int UPFS_PIN_TX_ACT   = 2;
  localparam int UPFS_PIN_RX_ACT   = 3;
  localparam int UPFS_PIN_FLOW_OUT = 4;

  // ****************************************************************
  // Configuration byte layout
  // ****************************************************************
  localparam int UPFS_PULLUP_OFF_BIT = 7;
  localparam int UPFS_PULLDN_ON_BIT  = 6;
  localparam logic [7:0] UPFS_CFG_RESET  = 8'h00;
  localparam logic [7:0] UPFS_CFG_MASK2  = 8'hc3;
  localparam logic [7:0] UPFS_CFG_MASK3  = 8'hc7;

  // Control field codes
  localparam logic [2:0] UPFS_CTRL_IN     = 3'h0;
  localparam logic [2:0] UPFS_CTRL_OD     = 3'h1;
  localparam logic [2:0] UPFS_CTRL_PP     = 3'h2;
  localparam logic [2:0] UPFS_CTRL_FN     = 3'h3;
  localparam logic [2:0] UPFS_CTRL_FN_PP3 = 3'h4;

  typedef enum logic [2:0] {
    UPFS_MD_IN,
    UPFS_MD_OD,
    UPFS_MD_PP,
    UPFS_MD_FN_IN,
    UPFS_MD_FN_OD,
    UPFS_MD_FN_PP
  } upfs_mode_t;

  // ****************************************************************
  // Register word indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [UPFS_IDX_W-1:0] UPFS_CFG_IDX [UPFS_NCH][UPFS_NPIN] = '{
    '{10'h026, 10'h027, 10'h028, 10'h029, 10'h025},
    '{10'h039, 10'h03a, 10'h03b, 10'h03c, 10'h038}
  };
  localparam logic [UPFS_IDX_W-1:0] UPFS_GPIO_OUT_IDX [UPFS_NCH] = '{10'h080, 10'h082};
  localparam logic [UPFS_IDX_W-1:0] UPFS_GPIO_IN_IDX  [UPFS_NCH] = '{10'h081, 10'h083};

  // AXI responses
  localparam logic [1:0] UPFS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UPFS_RESP_SLVERR = 2'h2;

endpackage

/* File: rtl/upfs_pin_cell.sv */
// One multi-function pin: mode decode, drive and pull resistor control
`timescale 1ns/1ns
module upfs_pin_cell #(
  parameter int                  CTRL_W  = 2,
  parameter upfs_pkg::upfs_mode_t FN_MODE = upfs_pkg::UPFS_MD_FN_PP
) (
  // Configuration and sources
  input  logic [7:0]           cfg,
  input  logic                 gpio_val,
  input  logic                 func_val,
  // Pad controls
  output logic                 drv_o,
  output logic                 drv_oe,
  output logic                 pullup_en,
  output logic                 pulldown_en,
  output logic                 fn_input
);
  import upfs_pkg::*;

  logic [2:0]  ctrl;
  upfs_mode_t  mode;

  always_comb begin
    ctrl = (CTRL_W == 2) ? {1'b0, cfg[1:0]} : cfg[2:0];
    case (ctrl)
      UPFS_CTRL_IN:     mode = UPFS_MD_IN;
      UPFS_CTRL_OD:     mode = UPFS_MD_OD;
      UPFS_CTRL_PP:     mode = UPFS_MD_PP;
      UPFS_CTRL_FN:     mode = (CTRL_W == 2) ? FN_MODE : UPFS_MD_FN_OD;
      UPFS_CTRL_FN_PP3: mode = (CTRL_W == 3) ? UPFS_MD_FN_PP : UPFS_MD_IN;
      // Invalid codes fall back to a harmless input
      default:          mode = UPFS_MD_IN;
    endcase
  end

  always_comb begin
    drv_o       = 1'b0;
    drv_oe      = 1'b0;
    pullup_en   = 1'b0;
    pulldown_en = 1'b0;
    fn_input    = 1'b0;
    case (mode)
      UPFS_MD_IN, UPFS_MD_FN_IN: begin
        // Pull-up wins over pull-down; pulls only act in input modes
        pullup_en   = ~cfg[UPFS_PULLUP_OFF_BIT];
        pulldown_en = cfg[UPFS_PULLDN_ON_BIT] & cfg[UPFS_PULLUP_OFF_BIT];
        fn_input    = (mode == UPFS_MD_FN_IN);
      end
      UPFS_MD_OD:    drv_oe = ~gpio_val;
      UPFS_MD_PP: begin
        drv_o  = gpio_val;
        drv_oe = 1'b1;
      end
      UPFS_MD_FN_OD: drv_oe = ~func_val;
      UPFS_MD_FN_PP: begin
        drv_o  = func_val;
        drv_oe = 1'b1;
      end
      default: begin
        drv_o  = 1'b0;
        drv_oe = 1'b0;
      end
    endcase
  end

endmodule

/* File: rtl/upfs_pin_mux.sv */
// Pin function select for two serial channels with an AXI4-Lite register port
//
// Summary of operation
// - bit 7 set disconnects pull-up, clear enables
// - flow input pin pulls ignored in output modes
// - bit 6 set enables the pull-down
// - pull-up wins, pull-down then stays off
// - flow input field: input, OD, PP, clear-to-send
// - half-duplex code 11 drives transceiver enable
// - tx activity code 11 toggles with transmit
// - rx activity code 11 toggles with receive
// - two channels, identical bytes, separate offsets
// - half-duplex pin pulls ignored in output modes
// - request pin codes 011 OD, 100 PP
`timescale 1ns/1ns
module upfs_pin_mux (
  // Clock and reset
  input  logic                                                      core_clk,
  input  logic                                                      reset_n,
  // AXI4-Lite write address
  input  logic [upfs_pkg::UPFS_ADDR_W-1:0]                          awaddr,
  input  logic                                                      awvalid,
  output logic                                                      awready,
  // AXI4-Lite write data
  input  logic [upfs_pkg::UPFS_DATA_W-1:0]                          wdata,
  input  logic [3:0]                                                wstrb,
  input  logic                                                      wvalid,
  output logic                                                      wready,
  // AXI4-Lite write response
  output logic [1:0]                                                bresp,
  output logic                                                      bvalid,
  input  logic                                                      bready,
  // AXI4-Lite read address
  input  logic [upfs_pkg::UPFS_ADDR_W-1:0]                          araddr,
  input  logic                                                      arvalid,
  output logic                                                      arready,
  // AXI4-Lite read data
  output logic [upfs_pkg::UPFS_DATA_W-1:0]                          rdata,
  output logic [1:0]                                                rresp,
  output logic                                                      rvalid,
  input  logic                                                      rready,
  // Serial engine side, one bit per channel
  input  logic [upfs_pkg::UPFS_NCH-1:0]                             tx_busy,
  input  logic [upfs_pkg::UPFS_NCH-1:0]                             tx_event,
  input  logic [upfs_pkg::UPFS_NCH-1:0]                             rx_event,
  input  logic [upfs_pkg::UPFS_NCH-1:0]                             rts_request,
  output logic [upfs_pkg::UPFS_NCH-1:0]                             flow_clear,
  // Pads: [channel][flow_input, halfduplex_enable, tx_activity, rx_activity, flow_output]
  input  logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0]   pin_in,
  output logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0]   pin_out,
  output logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0]   pin_oe,
  output logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0]   pin_pullup_en,
  output logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0]   pin_pulldown_en
);
  import upfs_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef logic [UPFS_NCH-1:0][UPFS_NPIN-1:0] upfs_pinvec_t;

  typedef struct packed {
    logic [UPFS_NCH-1:0][UPFS_NPIN-1:0][7:0] cfg;
    upfs_pinvec_t                            gpio_out;
    upfs_pinvec_t                            sync1;
    upfs_pinvec_t                            sync2;
    logic [UPFS_NCH-1:0]                     tx_tgl;
    logic [UPFS_NCH-1:0]                     rx_tgl;
    upfs_pinvec_t                            pin_o;
    upfs_pinvec_t                            pin_oe;
    upfs_pinvec_t                            pull_up;
    upfs_pinvec_t                            pull_dn;
    logic [UPFS_NCH-1:0]                     flow_clear;
    logic                                    aw_held;
    logic [UPFS_ADDR_W-1:0]                  aw_addr;
    logic                                    w_held;
    logic [UPFS_DATA_W-1:0]                  w_data;
    logic [3:0]                              w_strb;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic                                    rvalid;
    logic [UPFS_DATA_W-1:0]                  rdata;
    logic [1:0]                              rresp;
  } upfs_state_t;

  upfs_state_t   s_q;
  upfs_state_t   s_d;
  logic [1:0]    rst_pipe_q;
  logic          rst_sync_n;
  logic          aw_take;
  logic          w_take;
  logic          ar_take;
  logic          wr_hit;
  logic [UPFS_IDX_W-1:0] wr_idx;
  logic [UPFS_IDX_W-1:0] rd_idx;
  upfs_pinvec_t  cell_o;
  upfs_pinvec_t  cell_oe;
  upfs_pinvec_t  cell_pu;
  upfs_pinvec_t  cell_pd;
  upfs_pinvec_t  cell_fn_in;
  upfs_pinvec_t  func_val;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  // Assert asynchronously, release on the clock so no flop sees a runt edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_q[1];

  // ****************************************************************
  // Pin cells
  // ****************************************************************
  always_comb begin
    for (int c = 0; c < UPFS_NCH; c++) begin
      func_val[c][UPFS_PIN_FLOW_IN]  = 1'b0;
      func_val[c][UPFS_PIN_HALFDUP]  = tx_busy[c];
      func_val[c][UPFS_PIN_TX_ACT]   = s_q.tx_tgl[c];
      func_val[c][UPFS_PIN_RX_ACT]   = s_q.rx_tgl[c];
      // The request line is active low on the pad
      func_val[c][UPFS_PIN_FLOW_OUT] = ~rts_request[c];
    end
  end

  // Each channel gets the same cell set at its own register slots
  for (genvar c = 0; c < UPFS_NCH; c++) begin : g_ch
    for (genvar p = 0; p < UPFS_NPIN; p++) begin : g_pin
      upfs_pin_cell #(
        .CTRL_W  ((p == UPFS_PIN_FLOW_OUT) ? 3 : 2),
        .FN_MODE ((p == UPFS_PIN_FLOW_IN) ? UPFS_MD_FN_IN : UPFS_MD_FN_PP)
      ) u_cell (
        .cfg         (s_q.cfg[c][p]),
        .gpio_val    (s_q.gpio_out[c][p]),
        .func_val    (func_val[c][p]),
        .drv_o       (cell_o[c][p]),
        .drv_oe      (cell_oe[c][p]),
        .pullup_en   (cell_pu[c][p]),
        .pulldown_en (cell_pd[c][p]),
        .fn_input    (cell_fn_in[c][p])
      );
    end
  end

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  // One write and one read in flight; new requests wait for the response
  assign awready = ~s_q.aw_held & ~s_q.bvalid;
  assign wready  = ~s_q.w_held & ~s_q.bvalid;
  assign arready = ~s_q.rvalid;
  assign aw_take = awvalid & awready;
  assign w_take  = wvalid & wready;
  assign ar_take = arvalid & arready;
  assign rd_idx  = araddr[UPFS_ADDR_W-1:2];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d    = s_q;
    wr_hit = 1'b0;
    wr_idx = s_q.aw_addr[UPFS_ADDR_W-1:2];

    // Two-stage pad synchroniser; only the second stage is used
    s_d.sync1 = pin_in;
    s_d.sync2 = s_q.sync1;

    for (int c = 0; c < UPFS_NCH; c++) begin
      if (tx_event[c]) begin
        s_d.tx_tgl[c] = ~s_q.tx_tgl[c];
      end
      if (rx_event[c]) begin
        s_d.rx_tgl[c] = ~s_q.rx_tgl[c];
      end
      // Clear-to-send is active low; without the function the engine is never held
      s_d.flow_clear[c] = cell_fn_in[c][UPFS_PIN_FLOW_IN] ? ~s_q.sync2[c][UPFS_PIN_FLOW_IN] : 1'b1;
    end

    // Pad drive and pulls from the decoded modes
    s_d.pin_o   = cell_o;
    s_d.pin_oe  = cell_oe;
    s_d.pull_up = cell_pu;
    s_d.pull_dn = cell_pd;

    // Write channel: address and data may arrive in either order
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (aw_take) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = awaddr;
      wr_idx      = awaddr[UPFS_ADDR_W-1:2];
    end
    if (w_take) begin
      s_d.w_held = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_d.aw_held && s_d.w_held) begin
      for (int c = 0; c < UPFS_NCH; c++) begin
        for (int p = 0; p < UPFS_NPIN; p++) begin
          if (wr_idx == UPFS_CFG_IDX[c][p]) begin
            wr_hit = 1'b1;
            // Reserved bits are not stored, so a careless write cannot leak into them
            if (s_d.w_strb[0]) begin
              s_d.cfg[c][p] = s_d.w_data[7:0] & ((p == UPFS_PIN_FLOW_OUT) ? UPFS_CFG_MASK3 : UPFS_CFG_MASK2);
            end
          end
        end
        if (wr_idx == UPFS_GPIO_OUT_IDX[c]) begin
          wr_hit = 1'b1;
          if (s_d.w_strb[0]) begin
            s_d.gpio_out[c] = s_d.w_data[UPFS_NPIN-1:0];
          end
        end
        if (wr_idx == UPFS_GPIO_IN_IDX[c]) begin
          wr_hit = 1'b1;
        end
      end
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = wr_hit ? UPFS_RESP_OKAY : UPFS_RESP_SLVERR;
    end

    // Read channel: data one cycle after the address is taken
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = '0;
      s_d.rresp  = UPFS_RESP_SLVERR;
      for (int c = 0; c < UPFS_NCH; c++) begin
        for (int p = 0; p < UPFS_NPIN; p++) begin
          if (rd_idx == UPFS_CFG_IDX[c][p]) begin
            s_d.rdata[7:0] = s_q.cfg[c][p];
            s_d.rresp      = UPFS_RESP_OKAY;
          end
        end
        if (rd_idx == UPFS_GPIO_OUT_IDX[c]) begin
          s_d.rdata[UPFS_NPIN-1:0] = s_q.gpio_out[c];
          s_d.rresp                = UPFS_RESP_OKAY;
        end
        if (rd_idx == UPFS_GPIO_IN_IDX[c]) begin
          s_d.rdata[UPFS_NPIN-1:0] = s_q.sync2[c];
          s_d.rresp                = UPFS_RESP_OKAY;
        end
      end
    end
  end

  // All-zero reset gives every byte UPFS_CFG_RESET: pulled-up inputs
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bvalid          = s_q.bvalid;
  assign bresp           = s_q.bresp;
  assign rvalid          = s_q.rvalid;
  assign rdata           = s_q.rdata;
  assign rresp           = s_q.rresp;
  assign flow_clear      = s_q.flow_clear;
  assign pin_out         = s_q.pin_o;
  assign pin_oe          = s_q.pin_oe;
  assign pin_pullup_en   = s_q.pull_up;
  assign pin_pulldown_en = s_q.pull_dn;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  logic [1:0] ctl_fi;
  logic [1:0] ctl_hd;
  logic [1:0] ctl_tx;
  logic [1:0] ctl_rx;
  logic [2:0] ctl_fo;
  logic [7:0] cfg_fi;
  assign cfg_fi = s_q.cfg[0][UPFS_PIN_FLOW_IN];
  assign ctl_fi = cfg_fi[1:0];
  assign ctl_hd = s_q.cfg[0][UPFS_PIN_HALFDUP][1:0];
  assign ctl_tx = s_q.cfg[1][UPFS_PIN_TX_ACT][1:0];
  assign ctl_rx = s_q.cfg[1][UPFS_PIN_RX_ACT][1:0];
  assign ctl_fo = s_q.cfg[0][UPFS_PIN_FLOW_OUT][2:0];

  property p_pullup_on;
    (ctl_fi == 2'h0 && !cfg_fi[7]) |=> (pin_pullup_en[0][0] && !pin_pulldown_en[0][0]);
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("pull-up not on for input");

  property p_pulldown_on;
    (ctl_fi == 2'h0 && cfg_fi[7] && cfg_fi[6]) |=> (pin_pulldown_en[0][0] && !pin_pullup_en[0][0]);
  endproperty
  a_pulldown_on: assert property (p_pulldown_on) else $error("pull-down not on for input");

  property p_pullup_wins;
    ((ctl_fi == 2'h0 || ctl_fi == 2'h3) && !cfg_fi[7] && cfg_fi[6]) |=> !pin_pulldown_en[0][0];
  endproperty
  a_pullup_wins: assert property (p_pullup_wins) else $error("pull-down on beside pull-up");

  property p_flow_in_out_nopull;
    (ctl_fi == 2'h1 || ctl_fi == 2'h2) |=> (!pin_pullup_en[0][0] && !pin_pulldown_en[0][0] && pin_oe[0][0] == $past(ctl_fi == 2'h2 || !s_q.gpio_out[0][0]));
  endproperty
  a_flow_in_out_nopull: assert property (p_flow_in_out_nopull) else $error("flow input pin output mode wrong");

  property p_clear_follows_pin;
    (ctl_fi == 2'h3)[*2] |=> (flow_clear[0] == !$past(s_q.sync2[0][0]) && !pin_oe[0][0]);
  endproperty
  a_clear_follows_pin: assert property (p_clear_follows_pin) else $error("clear-to-send not from pad");

  property p_hd_enable;
    (ctl_hd == 2'h3) |=> (pin_oe[0][1] && pin_out[0][1] == $past(tx_busy[0]) && !pin_pullup_en[0][1]);
  endproperty
  a_hd_enable: assert property (p_hd_enable) else $error("half-duplex enable not following transmit");

  property p_hd_nopull;
    (ctl_hd != 2'h0) |=> (!pin_pullup_en[0][1] && !pin_pulldown_en[0][1]);
  endproperty
  a_hd_nopull: assert property (p_hd_nopull) else $error("half-duplex pin pulled while output");

  property p_tx_toggle;
    (tx_event[1] && ctl_tx == 2'h3) ##1 (ctl_tx == 2'h3) |=> (pin_out[1][2] != $past(pin_out[1][2]) && pin_oe[1][2]);
  endproperty
  a_tx_toggle: assert property (p_tx_toggle) else $error("tx activity pin did not toggle");

  property p_rx_toggle;
    (rx_event[1] && ctl_rx == 2'h3) ##1 (ctl_rx == 2'h3) |=> (pin_out[1][3] != $past(pin_out[1][3]) && pin_oe[1][3]);
  endproperty
  a_rx_toggle: assert property (p_rx_toggle) else $error("rx activity pin did not toggle");

  property p_request_od;
    (ctl_fo == 3'h3) |=> (!pin_out[0][4] && pin_oe[0][4] == $past(rts_request[0]));
  endproperty
  a_request_od: assert property (p_request_od) else $error("open-drain request drive wrong");

  property p_request_pp;
    (ctl_fo == 3'h4) |=> (pin_oe[0][4] && pin_out[0][4] == !$past(rts_request[0]));
  endproperty
  a_request_pp: assert property (p_request_pp) else $error("push-pull request drive wrong");

endmodule

/* File: bench/upfs_pad_model.sv */
// Far-side model: line parties, device pull levels and pad resolution for every pin
`timescale 1ns/1ns
module upfs_pad_model
  import upfs_pkg::*;
(
  // Clock
  input  wire logic                                                   core_clk,
  // Device pad controls
  input  wire logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0] pin_out,
  input  wire logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0] pin_oe,
  input  wire logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0] pin_pullup_en,
  input  wire logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0] pin_pulldown_en,
  // External drivers
  input  wire logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0] ext_en,
  input  wire logic [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0] ext_lvl,
  // Resolved pad level
  output logic      [upfs_pkg::UPFS_NCH-1:0][upfs_pkg::UPFS_NPIN-1:0] pad
);
  logic flt_q = 1'b0;

  // A floating pad wanders so an unknown is never read as a steady level
  always @(posedge core_clk) begin
    flt_q <= ~flt_q;
  end

  always_comb begin
    for (int c = 0; c < UPFS_NCH; c++) begin
      for (int p = 0; p < UPFS_NPIN; p++) begin
        if (pin_oe[c][p]) begin
          pad[c][p] = pin_out[c][p];
        end else if (ext_en[c][p]) begin
          pad[c][p] = ext_lvl[c][p];
        end else if (pin_pullup_en[c][p]) begin
          pad[c][p] = 1'b1;
        end else if (pin_pulldown_en[c][p]) begin
          pad[c][p] = 1'b0;
        end else begin
          pad[c][p] = flt_q;
        end
      end
    end
  end
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the serial pin function select block
`timescale 1ns/1ns
module tb_top;
  import upfs_pkg::*;
  typedef struct packed {
    logic [7:0] wd;
    logic [7:0] rb;
    logic       ch;
    logic [2:0] p;
    logic       oe;
    logic       pu;
    logic       pd;
  } upfs_row_t;
  localparam upfs_row_t ROWS [10] = '{
    '{8'h80, 8'h80, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0}, '{8'hc0, 8'hc0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1},
    '{8'h40, 8'h40, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0}, '{8'hfd, 8'hc1, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0},
    '{8'h02, 8'h02, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0}, '{8'h42, 8'h42, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0},
    '{8'hc3, 8'hc3, 1'b1, 3'h2, 1'b1, 1'b0, 1'b0}, '{8'h03, 8'h03, 1'b1, 3'h3, 1'b1, 1'b0, 1'b0},
    '{8'h80, 8'h80, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0}, '{8'h3c, 8'h04, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0}};

  logic            core_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic [11:0]     awaddr = '0, araddr = '0;
  logic [31:0]     wdata = '0, rdata, d;
  logic [3:0]      wstrb = '0;
  logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic            awready, wready, bvalid, arready, rvalid, prev;
  logic [1:0]      bresp, rresp, r;
  logic [1:0]      tx_busy = '0, tx_event = '0, rx_event = '0, rts_request = '0, flow_clear;
  logic [1:0][4:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_pulldown_en, ext_en = '0, ext_lvl = '0;
  int              num_errors = 0, cmp_count = 0, cyc = 0;

  upfs_pin_mux u_dut (.core_clk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .tx_busy,
    .tx_event, .rx_event, .rts_request, .flow_clear, .pin_in, .pin_out, .pin_oe, .pin_pullup_en,
    .pin_pulldown_en);
  upfs_pad_model u_pad (.core_clk, .pin_out, .pin_oe, .pin_pullup_en, .pin_pulldown_en, .ext_en,
    .ext_lvl, .pad(pin_in));

  always #50 core_clk = ~core_clk;

  // ****************************************************************
  // Checks, bus cycles and closing
  // ****************************************************************
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      finish_test;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Called just after a rising edge; returns one edge after the response
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rsp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [11:0] cfg_addr(input int c, input int p);
    return {UPFS_CFG_IDX[c][p], 2'b00};
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    tick(20);
    reset_n <= 1'b1;
    tick(4);
    foreach (ROWS[i]) begin
      axi_wr(cfg_addr(ROWS[i].ch, ROWS[i].p), {24'h0, ROWS[i].wd}, 4'hf, r);
      chk_resp("write resp", UPFS_RESP_OKAY, r);
      chk_bit("oe", ROWS[i].oe, pin_oe[ROWS[i].ch][ROWS[i].p]);
      chk_bit("pullup", ROWS[i].pu, pin_pullup_en[ROWS[i].ch][ROWS[i].p]);
      chk_bit("pulldown", ROWS[i].pd, pin_pulldown_en[ROWS[i].ch][ROWS[i].p]);
      axi_rd(cfg_addr(ROWS[i].ch, ROWS[i].p), d, r);
      chk_word("readback", {24'h0, ROWS[i].rb}, d);
    end
    // Transceiver enable follows the transmitter
    axi_wr(cfg_addr(0, 1), 32'h03, 4'hf, r);
    tx_busy <= 2'b01;
    tick(2);
    chk_bit("halfduplex busy", 1'b1, pin_out[0][1]);
    tx_busy <= 2'b00;
    tick(2);
    chk_bit("halfduplex idle", 1'b0, pin_out[0][1]);
    // Push-pull GPIO level reaches the pad and returns through the input word
    axi_wr(12'h200, 32'h01, 4'hf, r);
    chk_bit("gpio drive", 1'b1, pin_out[0][0]);
    tick(2);
    axi_rd(12'h204, d, r);
    chk_word("gpio input", 32'h1d, d);
    // Activity toggles on channel 1
    for (int k = 2; k < 4; k++) begin
      prev = pin_out[1][k];
      if (k == 2) begin
        tx_event <= 2'b10;
      end else begin
        rx_event <= 2'b10;
      end
      tick(1);
      tx_event <= 2'b00;
      rx_event <= 2'b00;
      tick(2);
      chk_bit("activity toggle", ~prev, pin_out[1][k]);
    end
    // Clear-to-send with its companion request output set up first
    axi_wr(cfg_addr(0, 4), 32'h03, 4'hf, r);
    rts_request <= 2'b01;
    tick(2);
    chk_bit("request od drive", 1'b1, pin_oe[0][4]);
    chk_bit("request od low", 1'b0, pin_out[0][4]);
    axi_wr(cfg_addr(0, 4), 32'h04, 4'hf, r);
    axi_wr(cfg_addr(0, 0), 32'h03, 4'hf, r);
    rts_request <= 2'b01;
    ext_en[0][0] <= 1'b1;
    ext_lvl[0][0] <= 1'b0;
    tick(5);
    chk_bit("clear low pad", 1'b1, flow_clear[0]);
    chk_bit("request pad", 1'b0, pin_out[0][4]);
    ext_lvl[0][0] <= 1'b1;
    tick(5);
    chk_bit("clear high pad", 1'b0, flow_clear[0]);
    // Lane 0 strobe off leaves the byte alone; unmapped word errors
    axi_wr(cfg_addr(0, 0), 32'hff, 4'he, r);
    axi_rd(cfg_addr(0, 0), d, r);
    chk_word("masked write", 32'h03, d);
    axi_wr(12'h000, 32'h55, 4'hf, r);
    chk_resp("unmapped write", UPFS_RESP_SLVERR, r);
    axi_rd(12'h000, d, r);
    chk_resp("unmapped read", UPFS_RESP_SLVERR, r);
    chk_word("unmapped data", 32'h0, d);
    // Reset in mid-run returns every pin to a pulled-up input
    reset_n <= 1'b0;
    tick(2);
    chk_word("oe in reset", 32'h0, {22'h0, pin_oe});
    reset_n <= 1'b1;
    tick(4);
    chk_word("pullups", 32'h3ff, {22'h0, pin_pullup_en});
    chk_word("pulldowns", 32'h0, {22'h0, pin_pulldown_en});
    chk_word("oe", 32'h0, {22'h0, pin_oe});
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 4; p++) begin
        axi_rd(cfg_addr(c, p), d, r);
        chk_word("reset value", 32'h0, d);
      end
    end
    finish_test;
  end
endmodule
